// [ddct_timer.sv]
// dual down counter timer with plain register port
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
`include "ddct_params.svh"
module ddct_timer #(
  parameter int NUM_CNT = 2,
  parameter int CNT_W = 32
) (
  input wire logic sys_clk_i, // common tick source clock
  input wire logic nrst_i, // async reset, active low
  input wire ddct_pkg::ddct_req_s req_i, // addr, wdata, wr, rd
  output logic [31:0] rdata_o, // read data, cycle after rd
  output logic [NUM_CNT-1:0] irq_o // masked interrupt per counter
);
  import ddct_pkg::*;

  // reset control word is kept in register layout; unpack it by field
  // so that the struct order never has to match the bit positions
  localparam logic [7:0] CTL_RST_RAW = `DDCT_RST_CTRL;
  localparam ddct_ctrl_s CTL_RST = '{
    count_enable: CTL_RST_RAW[`DDCT_CTL_ENABLE],
    periodic_select: CTL_RST_RAW[`DDCT_CTL_PERIODIC],
    irq_unmask: CTL_RST_RAW[`DDCT_CTL_UNMASK],
    tick_divider_sel: CTL_RST_RAW[`DDCT_CTL_DIV_HI:`DDCT_CTL_DIV_LO],
    width_select: CTL_RST_RAW[`DDCT_CTL_WIDTH],
    single_run_select: CTL_RST_RAW[`DDCT_CTL_SINGLE]
  };

  // ************************************************************
  // address decode
  // ************************************************************
  logic [NUM_CNT-1:0] bank_hit;
  logic [7:0] local_addr;
  assign local_addr = req_i.addr & (`DDCT_BANK_STRIDE - 8'h01);

  logic [NUM_CNT-1:0] irq_raw;
  logic [NUM_CNT-1:0][31:0] cnt_rd;
  logic [NUM_CNT-1:0][31:0] rel_rd;
  ddct_ctrl_s [NUM_CNT-1:0] ctl_rd;

  // ************************************************************
  // counter channels
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_CNT; g++) begin : g_cnt
      ddct_ctrl_s ctl_q, ctl_d;
      logic [CNT_W-1:0] cnt_q, cnt_d;
      logic [CNT_W-1:0] rel_q, rel_d;
      logic [7:0] pre_q, pre_d;
      logic pend_q, pend_d;
      logic halt_q, halt_d;
      logic raw_q, raw_d;
      logic wr_hit, tick, zero_now;
      ddct_mode_e mode;

      assign bank_hit[g] = (req_i.addr[7:5] == 3'(g));
      assign wr_hit = req_i.wr && bank_hit[g];

      always_comb begin
        if (ctl_q.single_run_select) begin
          mode = DDCT_SINGLE;
        end else if (ctl_q.periodic_select) begin
          mode = DDCT_PERIODIC;
        end else begin
          mode = DDCT_FREE;
        end
      end

      // divide by 1, 16 or 256; code 3 behaves as divide by 1
      always_comb begin
        pre_d = pre_q;
        tick = 1'b0;
        if (ctl_q.count_enable) begin
          unique case (ctl_q.tick_divider_sel)
            `DDCT_DIV_16: tick = (pre_q >= `DDCT_PRE_16_LAST);
            `DDCT_DIV_256: tick = (pre_q == `DDCT_PRE_256_LAST);
            default: tick = 1'b1;
          endcase
          pre_d = tick ? 8'h00 : pre_q + 8'h01;
        end
      end

      // zero test on the low half only in 16-bit mode
      assign zero_now = ctl_q.width_select ? (cnt_q == '0) :
                        (cnt_q[15:0] == 16'h0000);

      always_comb begin
        ctl_d = ctl_q;
        cnt_d = cnt_q;
        rel_d = rel_q;
        pend_d = pend_q;
        halt_d = halt_q;
        raw_d = raw_q;
        if (tick && pend_q) begin
          cnt_d = rel_q;
          pend_d = 1'b0;
          halt_d = 1'b0;
        end else if (tick && !halt_q) begin // hold when off
          if (zero_now) begin
            raw_d = 1'b1;
            unique case (mode)
              DDCT_FREE: begin
                if (ctl_q.width_select) begin
                  cnt_d = '1;
                end else begin
                  cnt_d[15:0] = `DDCT_HALF_ONES;
                end
              end
              DDCT_PERIODIC: begin
                if (ctl_q.width_select) begin
                  cnt_d = rel_q;
                end else begin
                  cnt_d[15:0] = rel_q[15:0];
                end
              end
              DDCT_SINGLE: halt_d = 1'b1;
            endcase
          end else if (ctl_q.width_select) begin
            cnt_d = cnt_q - 1'b1;
          end else begin
            cnt_d[15:0] = cnt_q[15:0] - 16'h0001;
          end
        end
        if (wr_hit) begin
          unique case (local_addr)
            `DDCT_OFF_RELOAD: begin
              rel_d = req_i.wdata[CNT_W-1:0];
              pend_d = 1'b1;
            end
            `DDCT_OFF_DEFER: rel_d = req_i.wdata[CNT_W-1:0];
            `DDCT_OFF_CTRL: begin
              ctl_d.count_enable = req_i.wdata[`DDCT_CTL_ENABLE];
              ctl_d.periodic_select = req_i.wdata[`DDCT_CTL_PERIODIC];
              ctl_d.irq_unmask = req_i.wdata[`DDCT_CTL_UNMASK];
              ctl_d.tick_divider_sel =
                req_i.wdata[`DDCT_CTL_DIV_HI:`DDCT_CTL_DIV_LO];
              ctl_d.width_select = req_i.wdata[`DDCT_CTL_WIDTH];
              ctl_d.single_run_select = req_i.wdata[`DDCT_CTL_SINGLE];
            end
            // set wins: a zero reached in the same cycle stays flagged
            `DDCT_OFF_CLEAR: raw_d = tick && !halt_q && !pend_q &&
                                     zero_now;
            default: ;
          endcase
        end
      end

      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          ctl_q <= CTL_RST;
          cnt_q <= CNT_W'(`DDCT_RST_COUNT);
          rel_q <= CNT_W'(`DDCT_RST_RELOAD);
          pre_q <= 8'h00;
          pend_q <= 1'b0;
          halt_q <= 1'b0;
          raw_q <= 1'b0;
        end else begin
          ctl_q <= ctl_d;
          cnt_q <= cnt_d;
          rel_q <= rel_d;
          pre_q <= pre_d;
          pend_q <= pend_d;
          halt_q <= halt_d;
          raw_q <= raw_d;
        end
      end

      assign irq_raw[g] = raw_q;
      assign irq_o[g] = raw_q & ctl_q.irq_unmask;
      assign cnt_rd[g] = 32'(cnt_q);
      assign rel_rd[g] = 32'(rel_q);
      assign ctl_rd[g] = ctl_q;
    end
  endgenerate

  // ************************************************************
  // read path
  // ************************************************************
  logic [31:0] rdata_q, rdata_d;
  ddct_ctrl_s c;

  always_comb begin
    rdata_d = 32'h00000000;
    c = '0;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (req_i.rd && bank_hit[i]) begin
        c = ctl_rd[i];
        unique case (local_addr)
          `DDCT_OFF_RELOAD, `DDCT_OFF_DEFER:
            rdata_d = rel_rd[i];
          `DDCT_OFF_COUNT: rdata_d = cnt_rd[i];
          `DDCT_OFF_CTRL: begin
            rdata_d[`DDCT_CTL_ENABLE] = c.count_enable;
            rdata_d[`DDCT_CTL_PERIODIC] = c.periodic_select;
            rdata_d[`DDCT_CTL_UNMASK] = c.irq_unmask;
            rdata_d[`DDCT_CTL_DIV_HI:`DDCT_CTL_DIV_LO] =
              c.tick_divider_sel;
            rdata_d[`DDCT_CTL_WIDTH] = c.width_select;
            rdata_d[`DDCT_CTL_SINGLE] = c.single_run_select;
          end
          `DDCT_OFF_RAW: rdata_d[0] = irq_raw[i];
          `DDCT_OFF_MASKED: rdata_d[0] = irq_raw[i] & c.irq_unmask;
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
endmodule

// [ddct_params.svh]
// constants for the dual down counter timer
`ifndef DDCT_PARAMS_SVH
`define DDCT_PARAMS_SVH
// register offsets within one counter bank (byte addresses)
`define DDCT_OFF_RELOAD 8'h00
`define DDCT_OFF_COUNT 8'h04
`define DDCT_OFF_CTRL 8'h08
`define DDCT_OFF_CLEAR 8'h0c
`define DDCT_OFF_RAW 8'h10
`define DDCT_OFF_MASKED 8'h14
`define DDCT_OFF_DEFER 8'h18
// bank stride: counter 1 sits at this offset
`define DDCT_BANK_STRIDE 8'h20
// control field positions
`define DDCT_CTL_ENABLE 7
`define DDCT_CTL_PERIODIC 6
`define DDCT_CTL_UNMASK 5
`define DDCT_CTL_DIV_HI 3
`define DDCT_CTL_DIV_LO 2
`define DDCT_CTL_WIDTH 1
`define DDCT_CTL_SINGLE 0
// reset values
`define DDCT_RST_COUNT 32'hffffffff
`define DDCT_RST_RELOAD 32'h00000000
`define DDCT_RST_CTRL 8'h20
// prescale codes and terminal counts
`define DDCT_DIV_1 2'h0
`define DDCT_DIV_16 2'h1
`define DDCT_DIV_256 2'h2
`define DDCT_PRE_16_LAST 8'h0f
`define DDCT_PRE_256_LAST 8'hff
`define DDCT_HALF_ONES 16'hffff
`endif

// [ddct_pkg.sv]
// types for the dual down counter timer
package ddct_pkg;
  typedef struct packed {
    logic count_enable;
    logic periodic_select;
    logic irq_unmask;
    logic [1:0] tick_divider_sel;
    logic width_select;
    logic single_run_select;
  } ddct_ctrl_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ddct_req_s;
  typedef enum logic [1:0] {
    DDCT_FREE,
    DDCT_PERIODIC,
    DDCT_SINGLE
  } ddct_mode_e;
endpackage

// [ddct_timer_properties.sv]
// port checker for the dual down counter timer
`timescale 1ns/1ns
module ddct_timer_properties #(
  parameter int NUM_CNT = 2,
  parameter int CNT_W = 32
) (
  input wire logic sys_clk_i, // common clock
  input wire logic nrst_i, // async reset, active low
  input wire ddct_pkg::ddct_req_s req_i, // register request
  input wire logic [31:0] rdata_o, // read data
  input wire logic [NUM_CNT-1:0] irq_o // masked interrupts
);
  import ddct_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // helpers: bank 0 strobes and offset
  // ****************************************
  logic rd0;
  logic wr0;
  logic [4:0] off;
  assign rd0 = req_i.rd && req_i.addr[7:5] == 3'h0;
  assign wr0 = req_i.wr && req_i.addr[7:5] == 3'h0;
  assign off = req_i.addr[4:0];
  // ****************************************
  // properties
  // ****************************************
  property p_idle;
    !$past(req_i.rd) |-> rdata_o == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("rdata without read");
  property p_bad_bank;
    req_i.rd && req_i.addr[7:6] != 2'h0 |=> rdata_o == 32'h0;
  endproperty
  a_bad_bank: assert property (p_bad_bank) else $error("bank 2+ read");
  property p_no_map;
    rd0 && off inside {5'h0c, 5'h1c} |=> rdata_o == 32'h0;
  endproperty
  a_no_map: assert property (p_no_map) else $error("unmapped read");
  property p_load_back;
    wr0 && off inside {5'h00, 5'h18} ##2 rd0 && off inside {5'h00, 5'h18}
      |=> rdata_o == $past(req_i.wdata, 3);
  endproperty
  a_load_back: assert property (p_load_back) else $error("load readback");
  property p_ctrl_back;
    wr0 && off == 5'h08 ##2 rd0 && off == 5'h08
      |=> rdata_o == ($past(req_i.wdata, 3) & 32'hef);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("ctrl readback");
  property p_clr_irq;
    wr0 && off == 5'h0c |-> ##[1:2] !irq_o[0];
  endproperty
  a_clr_irq: assert property (p_clr_irq) else $error("irq not cleared");
  property p_irq_hold;
    $fell(irq_o[0]) |-> $past(req_i.wr) || $past(req_i.wr, 2);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  property p_clr_raw;
    wr0 && off == 5'h0c ##2 rd0 && off == 5'h10 |=> !rdata_o[0];
  endproperty
  a_clr_raw: assert property (p_clr_raw) else $error("raw after clear");
  c_irq0: cover property (irq_o[0]);
  c_irq1: cover property (irq_o[1]);
  c_fall: cover property ($fell(irq_o[0]));
endmodule
bind ddct_timer ddct_timer_properties #(.NUM_CNT(NUM_CNT), .CNT_W(CNT_W))
  chk_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i),
  .rdata_o(rdata_o), .irq_o(irq_o));

// [tb.sv]
// self-checking bench for the dual down counter timer
`timescale 1ns/1ns
module tb;
  import ddct_pkg::*;
  typedef struct packed {logic rd; logic [7:0] a; logic [31:0] d;} ddct_row_s;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  ddct_req_s req_i = '0;
  logic [31:0] rdata_o;
  logic [1:0] irq_o;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] v;
  logic [31:0] w;
  logic [7:0] b;
  ddct_row_s rows [17] = '{'{1'b1, 8'h08, 32'h20}, '{1'b1, 8'h04, 32'hffffffff},
    '{1'b1, 8'h00, 32'h0}, '{1'b1, 8'h10, 32'h0}, '{1'b1, 8'h14, 32'h0},
    '{1'b1, 8'h28, 32'h20}, '{1'b1, 8'h1c, 32'h0}, '{1'b1, 8'h40, 32'h0},
    '{1'b0, 8'h00, 32'h5}, '{1'b0, 8'h18, 32'h9}, '{1'b1, 8'h00, 32'h9},
    '{1'b1, 8'h18, 32'h9}, '{1'b0, 8'h04, 32'h7}, '{1'b1, 8'h04, 32'hffffffff},
    '{1'b0, 8'h08, 32'h7b}, '{1'b1, 8'h08, 32'h6b}, '{1'b0, 8'h08, 32'h20}};
  ddct_timer dut_u (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    req_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge sys_clk_i);
    req_i.addr <= a;
    req_i.rd <= 1'b1;
    @(posedge sys_clk_i);
    req_i.rd <= 1'b0;
    #1 q = rdata_o;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    close_out;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].rd) begin
        rd(rows[i].a, v);
        chk("row", rows[i].d, v);
      end else begin
        wr(rows[i].a, rows[i].d);
      end
    end
    for (int k = 0; k < 2; k++) begin
      b = 8'(k * 32);
      wr(b + 8'h08, 32'ha2);
      wr(b, 32'h1);
      repeat (20) @(posedge sys_clk_i);
      rd(b + 8'h04, v);
      chk("wrap", 32'hffffff, {8'h0, v[31:8]});
      rd(b + 8'h10, v);
      chk("raw", 32'h1, v);
      chk("irq", 32'h1, {31'h0, irq_o[k]});
      wr(b + 8'h18, 32'h5);
      wr(b + 8'h08, 32'h22);
      rd(b + 8'h04, v);
      repeat (8) @(posedge sys_clk_i);
      rd(b + 8'h04, w);
      chk("hold", v, w);
      wr(b + 8'h08, 32'ha2);
      repeat (8) @(posedge sys_clk_i);
      rd(b + 8'h04, w);
      chk("resume", 32'h1, 32'(w < v && w > 32'hffff0000));
      wr(b + 8'h0c, 32'h0);
      rd(b + 8'h10, v);
      chk("clear", 32'h0, v);
      for (int p = 0; p < 3; p++) begin
        wr(b + 8'h08, 32'h22 | (p << 2));
        wr(b + 8'h08, 32'ha2 | (p << 2));
        rd(b + 8'h04, v);
        repeat (10 * (1 << (4 * p)) - 2) @(posedge sys_clk_i);
        rd(b + 8'h04, w);
        chk("rate", 32'd10, v - w);
      end
      wr(b + 8'h08, 32'h62);
      wr(b + 8'h08, 32'he2);
      wr(b, 32'h3);
      repeat (4) @(posedge sys_clk_i);
      rd(b + 8'h04, v);
      for (int j = 0; j < 6; j++) begin
        rd(b + 8'h04, w);
        chk("period", {30'h0, v[1:0] ^ 2'h2}, w);
        v = w;
      end
      wr(b + 8'h18, 32'h1);
      repeat (8) @(posedge sys_clk_i);
      rd(b + 8'h04, v);
      rd(b + 8'h04, w);
      chk("defer", {31'h0, v[0]}, w);
      wr(b + 8'h08, 32'h23);
      wr(b + 8'h0c, 32'h0);
      wr(b + 8'h08, 32'ha3);
      wr(b, 32'h0);
      repeat (6) @(posedge sys_clk_i);
      rd(b + 8'h04, v);
      chk("halt", 32'h0, v);
      rd(b + 8'h14, v);
      chk("masked", 32'h1, v);
      wr(b + 8'h08, 32'h83);
      @(posedge sys_clk_i);
      chk("mask", 32'h0, {31'h0, irq_o[k]});
      rd(b + 8'h14, v);
      chk("masked_off", 32'h0, v);
      rd(b + 8'h10, v);
      chk("raw_kept", 32'h1, v);
      wr(b, 32'h40);
      repeat (2) @(posedge sys_clk_i);
      rd(b + 8'h04, v);
      chk("restart", 32'h1, 32'(v > 0 && v <= 32'h40));
      chk("other", 32'h0, {31'h0, irq_o[1]});
    end
    // 16-bit free running: low half wraps, upper half left alone
    wr(8'h08, 32'h20);
    wr(8'h08, 32'ha0);
    wr(8'h00, 32'h00050002);
    wr(8'h0c, 32'h0);
    repeat (20) @(posedge sys_clk_i);
    rd(8'h04, v);
    chk("half_hi", 32'h5, {16'h0, v[31:16]});
    chk("half_lo", 32'h1, 32'(v[15:0] > 16'hff00));
    rd(8'h10, v);
    chk("half_raw", 32'h1, v);
    close_out;
  end
endmodule
